// ===== add_shift_table_op_decode_test.sv
// self-checking bench for the opcode decoder
`timescale 1ns/10ps
`default_nettype none
module add_shift_table_op_decode_test;
   logic        ref_clk, rstn, issue, extend_in, done_r, illegal_r, mem_form_r, left_r;
   logic        tbl_unsigned_r, tbl_raw_r;
   logic [15:0] op_word, ext_word;
   logic [31:0] index_operand_reg, shift_count_reg, base, step, ent_n, ent_n1;
   logic [3:0]  op_class_r;
   logic [1:0]  size_r, shift_type_r;
   logic [2:0]  reg_x_r, reg_y_r;
   logic [5:0]  ea_r, shift_count_r;
   logic [7:0]  tbl_offset_r;
   logic [39:0] result_r, e;
   integer      n_mismatch, compares, i, j, k;
   op_decode u_dut (.ref_clk, .rstn, .issue, .op_word, .ext_word, .src_data(ent_n),
      .src_alt(ent_n1), .index_operand_reg, .shift_count_reg, .extend_in, .done_r,
      .illegal_r, .op_class_r, .size_r, .reg_x_r, .reg_y_r, .ea_r, .mem_form_r, .left_r,
      .shift_type_r, .shift_count_r, .tbl_unsigned_r, .tbl_raw_r, .tbl_offset_r, .result_r);
   table_source u_src (.index_operand_reg, .base, .step, .entry_n(ent_n), .entry_n1(ent_n1));
   task chk(input logic [39:0] seen, input logic [39:0] want);
      compares = compares + 1;
      if (seen !== want)
      begin
         n_mismatch = n_mismatch + 1;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task run(input logic [15:0] op, input logic [15:0] ext);
      @(negedge ref_clk);
      op_word = op;
      ext_word = ext;
      issue = 1'h1;
      @(negedge ref_clk);
      issue = 1'h0;
   endtask
   task end_sim;
      if (n_mismatch == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // interpolated value, 32.8 signed, rounded to even when asked
   function logic [39:0] interp(input logic [31:0] a, input logic [31:0] b, input logic raw);
      logic signed [39:0] v;
      v = ($signed({{8{a[31]}}, a}) <<< 8) + $signed({32'h0, index_operand_reg[7:0]})
         * ($signed({{8{b[31]}}, b}) - $signed({{8{a[31]}}, a}));
      if (!raw)
         v = {8'h0, 32'(v >>> 8) + 32'(v[7] && (v[6:0] != 7'h0 || v[8]))};
      return v;
   endfunction
   initial
   begin
      ref_clk = 1'h0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   initial
   begin
      #(25 * 5000);
      n_mismatch = n_mismatch + 1;
      end_sim;
   end
   initial
   begin
      n_mismatch = 0;
      compares = 0;
      {rstn, issue, op_word, ext_word} = 34'h0;
      index_operand_reg = 32'h0000a380;
      shift_count_reg = 32'h5;
      extend_in = 1'h1;
      base = 32'd39;
      step = 32'd10;
      repeat (5) @(negedge ref_clk);
      rstn = 1'h1;
      run(16'hc78d, 16'h0);
      chk({done_r, op_class_r, reg_x_r, reg_y_r}, 11'h45d);
      chk(result_r, 40'h68f);
      // every opmode of the sum line
      for (i = 0; i < 8; i = i + 1)
      begin
         run({4'hd, 3'h1, i[2:0], 6'h10}, 16'h0);
         e = (i[1:0] == 2'h3) ? 40'h4 : {39'h1, i[2]};
         chk({op_class_r, size_r}, {e[3:0], i[1:0] == 2'h3 ? {i[2], !i[2]} : i[1:0]});
         chk(result_r, 40'hd14);
      end
      for (i = 0; i < 6; i = i + 1)
      begin
         extend_in = i[0];
         run({4'hd, 3'h2, 1'h1, i[2:1], 2'h0, i[0], 3'h4}, 16'h0);
         chk({op_class_r, size_r, mem_form_r, reg_x_r, reg_y_r}, {4'h5, i[2:1], i[0], 6'h14});
         chk(result_r, 40'hd14 + {39'h0, i[0]});
      end
      // register and memory shifts, all types and directions
      for (i = 0; i < 8; i = i + 1)
      begin
         run({4'he, 3'h0, i[2], 2'h2, 1'h0, i[1:0], 3'h1}, 16'h0);
         chk({op_class_r, left_r, shift_type_r, shift_count_r}, {4'h6, i[2:0], 6'h8});
         run({4'he, 1'h0, i[1:0], i[2], 2'h3, 6'h10}, 16'h0);
         chk({op_class_r, left_r, shift_type_r, size_r}, {4'h7, i[2:0], 2'h1});
      end
      run(16'he8a1, 16'h0);
      chk(shift_count_r, 6'h5);
      chk(result_r, 40'h34);
      run(16'he4d0, 16'h0);
      chk(result_r, 40'h0100008342);
      chk(ea_r, 6'h10);
      // table forms: example line, upper half set, two ties
      for (j = 0; j < 3; j = j + 1)
      begin
         base = (j == 0) ? 32'd39 : 32'd1506;
         step = (j == 0) ? 32'd10 : 32'd1;
         index_operand_reg = (j == 0) ? 32'h0000a380 : (j == 1) ? 32'hffffa380 : 32'h0000a480;
         for (k = 0; k < 8; k = k + 1)
         begin
            run(k[2] ? 16'hf803 : 16'hf810, {4'h2, k[1:0], 1'h0, !k[2], k[2] ? 8'h86 : 8'h40});
            e = interp(ent_n, ent_n1, k[0]);
            chk({op_class_r, tbl_unsigned_r, tbl_raw_r}, {3'h4, k[2], k[1:0]});
            chk({reg_x_r, reg_y_r, ea_r}, {3'h2, k[2] ? 9'h183 : 9'h010});
            chk(k[0] ? result_r : {8'h0, result_r[31:0]}, e);
            chk(tbl_offset_r, index_operand_reg[15:8]);
         end
      end
      // refused encodings leave state alone
      run(16'h0000, 16'h0);
      chk({illegal_r, done_r, op_class_r}, 6'h29);
      run(16'hf803, 16'h20c6);
      chk({illegal_r, done_r, op_class_r}, 6'h29);
      end_sim;
   end
endmodule
`default_nettype wire

// ===== op_decode.v
// decoder and executor for swap, sum, shift/rotate and table opcodes
`timescale 1ns/10ps
`default_nettype none
`include "op_decode_defs.vh"

module op_decode
(
   input  wire               ref_clk,       // core clock, 40 MHz
   input  wire               rstn,          // async reset, active low
   input  wire               issue,         // instruction words valid, pulse
   input  wire        [15:0] op_word,       // first opcode word
   input  wire        [15:0] ext_word,      // second word, table forms
   input  wire        [31:0] src_data,      // operand a from datapath
   input  wire        [31:0] src_alt,       // operand b (second endpoint)
   input  wire        [31:0] index_operand_reg, // table index register
   input  wire        [31:0] shift_count_reg,   // count data register value
   input  wire               extend_in,     // extend flag for rotate-x / ext sum
   output reg                done_r,        // result valid, one cycle
   output reg                illegal_r,     // illegal encoding, one cycle
   output reg         [3:0]  op_class_r,    // decoded operation class
   output reg         [1:0]  size_r,        // operation size
   output reg         [2:0]  reg_x_r,       // first register field
   output reg         [2:0]  reg_y_r,       // second register field
   output reg         [5:0]  ea_r,          // effective address field
   output reg                mem_form_r,    // predecrement memory form
   output reg                left_r,        // shift direction left
   output reg         [1:0]  shift_type_r,  // shift type
   output reg         [5:0]  shift_count_r, // resolved shift count
   output reg                tbl_unsigned_r, // table unsigned variant
   output reg                tbl_raw_r,     // table unrounded variant
   output reg         [7:0]  tbl_offset_r,  // table entry offset
   output reg         [39:0] result_r       // computed result
);

   ////////////////////////////////////////////////////////////////////
   // field extraction
   wire [3:0] line   = op_word[15:12];
   wire [2:0] f_hi   = op_word[11:9];
   wire [2:0] opmode = op_word[8:6];
   wire [1:0] f_size = op_word[7:6];
   wire [2:0] f_lo   = op_word[2:0];
   wire [1:0] x_size = ext_word[7:6];

   // table arithmetic, index low half only
   wire [15:0] idx = index_operand_reg[15:0];
   wire [39:0] interp;
   reg  [31:0] ent_lo;
   reg  [31:0] ent_hi;

   ////////////////////////////////////////////////////////////////////
   // endpoint extension by size and type
   always @*
   begin
      ent_lo = src_data;
      ent_hi = src_alt;
      case (x_size)
         `SIZE_BYTE:
         begin
            ent_lo = ext_word[11] ? {24'h0, src_data[7:0]} : {{24{src_data[7]}}, src_data[7:0]};
            ent_hi = ext_word[11] ? {24'h0, src_alt[7:0]} : {{24{src_alt[7]}}, src_alt[7:0]};
         end
         `SIZE_WORD:
         begin
            ent_lo = ext_word[11] ? {16'h0, src_data[15:0]} : {{16{src_data[15]}}, src_data[15:0]};
            ent_hi = ext_word[11] ? {16'h0, src_alt[15:0]} : {{16{src_alt[15]}}, src_alt[15:0]};
         end
         default:
         begin
            ent_lo = src_data;
            ent_hi = src_alt;
         end
      endcase
   end

   // four variants from type and round bits
   table_interp u_interp
   (
      .entry_lo    (ent_lo),
      .entry_hi    (ent_hi),
      .fraction    (idx[7:0]),
      .is_unsigned (ext_word[11]),
      .is_raw      (ext_word[10]),
      .result      (interp)
   );

   ////////////////////////////////////////////////////////////////////
   // shift controls straight from the opcode fields
   // a register count of zero leaves the operand untouched
   wire        sh_mem  = (f_size == `SIZE_BAD);
   wire        sh_left = op_word[8];
   wire [1:0]  sh_type = sh_mem ? op_word[10:9] : op_word[4:3];
   wire [1:0]  sh_size = sh_mem ? `SIZE_WORD : f_size;
   wire [5:0]  sh_imm  = {2'h0, (f_hi == 3'h0), f_hi};
   wire [5:0]  sh_cnt  = sh_mem ? `MEM_SHIFT_CNT : (op_word[5] ? shift_count_reg[5:0] : sh_imm);
   wire [39:0] sh_res;
   reg  [31:0] sh_val;
   reg  [31:0] sh_merged;
   reg  [4:0]  sh_top;
   reg         sh_x;
   reg         sh_out;
   reg         sh_in;
   integer     step;

   // top bit of the operand for the chosen size
   always @*
   begin
      case (sh_size)
         `SIZE_BYTE:
            sh_top = `TOP_BYTE;
         `SIZE_WORD:
            sh_top = `TOP_WORD;
         default:
            sh_top = `TOP_LONG;
      endcase
   end

   // one bit position per step, as many steps as the count
   always @*
   begin
      sh_val = src_data;
      sh_x   = extend_in;
      sh_out = 1'b0;
      sh_in  = 1'b0;
      for (step = 0; step < `MAX_SHIFT; step = step + 1)
      begin
         if (step < {26'h0, sh_cnt})
         begin
            // left when set, right when clear
            if (sh_left)
            begin
               sh_out = sh_val[sh_top];
               case (sh_type)
                  `SHT_ROTX:
                     sh_in = sh_x;
                  `SHT_ROT:
                     sh_in = sh_out;
                  default:
                     sh_in = 1'b0;
               endcase
               sh_val = {sh_val[30:0], sh_in};
            end
            else
            begin
               sh_out = sh_val[0];
               case (sh_type)
                  `SHT_ARITH:
                     sh_in = sh_val[sh_top];
                  `SHT_LOGIC:
                     sh_in = 1'b0;
                  `SHT_ROTX:
                     sh_in = sh_x;
                  default:
                     sh_in = sh_out;
               endcase
               sh_val         = {1'b0, sh_val[31:1]};
               sh_val[sh_top] = sh_in;
            end
            // plain rotate leaves the extend flag alone
            if (sh_type != `SHT_ROT)
               sh_x = sh_out;
         end
      end
   end

   // bits above the operand kept, extend flag above the result
   always @*
   begin
      case (sh_size)
         `SIZE_BYTE:
            sh_merged = {src_data[31:8], sh_val[7:0]};
         `SIZE_WORD:
            sh_merged = {src_data[31:16], sh_val[15:0]};
         default:
            sh_merged = sh_val;
      endcase
   end
   assign sh_res = {7'h00, sh_x, sh_merged};

   ////////////////////////////////////////////////////////////////////
   // decode
   reg  [3:0]  cls_nxt;
   reg  [1:0]  size_nxt;
   reg  [2:0]  rx_nxt;
   reg  [2:0]  ry_nxt;
   reg         mem_nxt;
   reg  [5:0]  cnt_nxt;
   reg  [39:0] res_nxt;
   reg  [31:0] sum;

   always @*
   begin
      cls_nxt  = `OP_NONE;
      size_nxt = `SIZE_BYTE;
      rx_nxt   = f_hi;
      ry_nxt   = f_lo;
      mem_nxt  = 1'b0;
      cnt_nxt  = 6'h00;
      res_nxt  = 40'h0;
      sum      = src_data + src_alt;
      case (line)
         `LINE_SWAP:
         begin
            if (op_word[8] && (op_word[7:3] == `SWAP_PATTERN))
            begin
               cls_nxt  = `OP_SWAP;
               size_nxt = `SIZE_LONG;
               res_nxt  = {8'h00, src_alt};
            end
         end
         `LINE_SUM:
         begin
            if (opmode == `OPM_ADDR_WORD || opmode == `OPM_ADDR_LONG)
            begin
               cls_nxt  = `OP_ADDR_SUM;
               size_nxt = opmode[2] ? `SIZE_LONG : `SIZE_WORD;
               res_nxt  = {8'h00, src_alt + (opmode[2] ? src_data : {{16{src_data[15]}}, src_data[15:0]})};
            end
            else if (op_word[8] && op_word[5:4] == 2'h0)
            begin
               cls_nxt  = `OP_EXT_SUM;
               size_nxt = f_size;
               mem_nxt  = op_word[3];
               res_nxt  = {8'h00, sum + {31'h0, extend_in}};
            end
            // sum to register or to ea
            else
            begin
               cls_nxt  = opmode[2] ? `OP_SUM_TO_EA : `OP_SUM_TO_REG;
               size_nxt = opmode[1:0];
               res_nxt  = {8'h00, sum};
            end
         end
         `LINE_SHIFT:
         begin
            if (f_size == 2'h3)
            begin
               if (!op_word[11])
               begin
                  cls_nxt  = `OP_SHIFT_MEM;
                  size_nxt = `SIZE_WORD;
                  cnt_nxt  = `MEM_SHIFT_CNT;
                  res_nxt  = sh_res;
               end
            end
            else
            begin
               cls_nxt  = `OP_SHIFT_REG;
               size_nxt = f_size;
               res_nxt  = sh_res;
               if (op_word[5])
                  cnt_nxt = shift_count_reg[5:0];
               else
                  cnt_nxt = {2'h0, (f_hi == 3'h0), f_hi};
            end
         end
         `LINE_TABLE:
         begin
            if (op_word[15:6] == `TABLE_HI_MEM && ext_word[15] == 1'b0
                && ext_word[9:8] == `TABLE_W1_MEM && ext_word[5:0] == 6'h00)
            begin
               cls_nxt  = `OP_TABLE_MEM;
               size_nxt = x_size;
               rx_nxt   = ext_word[14:12];
               res_nxt  = interp;
            end
            else if (op_word[15:3] == {`LINE_TABLE, 9'h100} && ext_word[15] == 1'b0
                && ext_word[9:8] == `TABLE_W1_REG && ext_word[5:3] == 3'h0)
            begin
               cls_nxt  = `OP_TABLE_REG;
               size_nxt = x_size;
               rx_nxt   = ext_word[14:12];
               ry_nxt   = ext_word[2:0];
               res_nxt  = interp;
            end
         end
         default:
         begin
            cls_nxt = `OP_NONE;
         end
      endcase
      if (size_nxt == `SIZE_BAD)
         cls_nxt = `OP_NONE;
   end

   ////////////////////////////////////////////////////////////////////
   // registered outputs
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         done_r         <= 1'b0;
         illegal_r      <= 1'b0;
         op_class_r     <= `OP_NONE;
         size_r         <= `SIZE_BYTE;
         reg_x_r        <= 3'h0;
         reg_y_r        <= 3'h0;
         ea_r           <= 6'h00;
         mem_form_r     <= 1'b0;
         left_r         <= 1'b0;
         shift_type_r   <= `SHT_ARITH;
         shift_count_r  <= 6'h00;
         tbl_unsigned_r <= 1'b0;
         tbl_raw_r      <= 1'b0;
         tbl_offset_r   <= 8'h00;
         result_r       <= 40'h0;
      end
      else
      begin
         done_r    <= issue && (cls_nxt != `OP_NONE);
         illegal_r <= issue && (cls_nxt == `OP_NONE);
         if (issue && cls_nxt != `OP_NONE)
         begin
            op_class_r    <= cls_nxt;
            size_r        <= size_nxt;
            reg_x_r       <= rx_nxt;
            reg_y_r       <= ry_nxt;
            ea_r          <= op_word[5:0];
            mem_form_r    <= mem_nxt;
            left_r        <= op_word[8];
            shift_type_r  <= (f_size == 2'h3) ? op_word[10:9] : op_word[4:3];
            shift_count_r <= cnt_nxt;
            tbl_unsigned_r <= ext_word[11];
            tbl_raw_r     <= ext_word[10];
            tbl_offset_r  <= idx[15:8];
            result_r      <= res_nxt;
         end
      end
   end

endmodule
`default_nettype wire

// ===== op_decode_chk.sv
// port-level checks for the opcode decoder
`timescale 1ns/10ps
`default_nettype none
module op_decode_chk
(
   input wire logic        ref_clk,           // core clock
   input wire logic        rstn,              // async reset
   input wire logic        issue,             // request
   input wire logic [15:0] op_word,           // first word
   input wire logic [31:0] index_operand_reg, // index
   input wire logic        done_r,            // legal answer
   input wire logic        illegal_r,         // refusal
   input wire logic [3:0]  op_class_r,        // class
   input wire logic [1:0]  size_r,            // size
   input wire logic [2:0]  reg_x_r,           // first reg
   input wire logic [2:0]  reg_y_r,           // second reg
   input wire logic        left_r,            // direction
   input wire logic [1:0]  shift_type_r,      // type
   input wire logic [5:0]  shift_count_r,     // count
   input wire logic [7:0]  tbl_offset_r       // offset
);
   logic [15:0] op_q;
   logic [7:0]  off_q;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // first word and index offset of the previous cycle
   always @(posedge ref_clk)
   begin
      op_q  <= op_word;
      off_q <= index_operand_reg[15:8];
   end
   property p_answer; issue |=> (done_r ^ illegal_r); endproperty
   a_answer: assert property (p_answer) else $error("no single answer");
   property p_quiet; !issue |=> !done_r && !illegal_r; endproperty
   a_quiet: assert property (p_quiet) else $error("answer without request");
   property p_swap;
      issue && op_word[15:12] == 4'hc && op_word[8:3] == 6'h31 |=> done_r
         && op_class_r == 4'h1 && reg_x_r == op_q[11:9] && reg_y_r == op_q[2:0];
   endproperty
   a_swap: assert property (p_swap) else $error("swap decode wrong");
   property p_addr;
      issue && op_word[15:12] == 4'hd && op_word[7:6] == 2'h3 |=> done_r
         && op_class_r == 4'h4 && size_r == (op_q[8] ? 2'h2 : 2'h1);
   endproperty
   a_addr: assert property (p_addr) else $error("address sum wrong");
   property p_type;
      done_r && op_class_r == 4'h6 |-> shift_type_r == op_q[4:3] && size_r == op_q[7:6];
   endproperty
   a_type: assert property (p_type) else $error("shift type wrong");
   property p_dir; done_r && op_class_r[3:1] == 3'h3 |-> left_r == op_q[8]; endproperty
   a_dir: assert property (p_dir) else $error("direction wrong");
   property p_mem;
      issue && op_word[15:11] == 5'h1c && op_word[7:6] == 2'h3 |=> done_r
         && op_class_r == 4'h7 && shift_type_r == op_q[10:9];
   endproperty
   a_mem: assert property (p_mem) else $error("memory shift wrong");
   property p_count;
      done_r && op_class_r == 4'h6 && !op_q[5] |->
         shift_count_r == (op_q[11:9] == 3'h0 ? 6'h8 : {3'h0, op_q[11:9]});
   endproperty
   a_count: assert property (p_count) else $error("count wrong");
   property p_offset; done_r && op_class_r == 4'h8 |-> tbl_offset_r == off_q; endproperty
   a_offset: assert property (p_offset) else $error("offset wrong");
   property p_refuse; illegal_r |-> $stable(op_class_r) && $stable(size_r); endproperty
   a_refuse: assert property (p_refuse) else $error("refusal changed state");
   c_swap: cover property (done_r && op_class_r == 4'h1);
   c_table: cover property (done_r && op_class_r == 4'h9);
   c_bad: cover property (illegal_r);
endmodule
bind op_decode op_decode_chk u_chk (.ref_clk, .rstn, .issue, .op_word, .index_operand_reg,
   .done_r, .illegal_r, .op_class_r, .size_r, .reg_x_r, .reg_y_r, .left_r, .shift_type_r,
   .shift_count_r, .tbl_offset_r);
`default_nettype wire

// ===== op_decode_defs.vh
// constants and field layout for the add, shift and table opcode decoder
//
// Contract
// - swap: line 1100, bit8 set, bits7-3 10001
// - line 1101 opmodes 0-2 and 4-6 add
// - opmode 011 word, 111 long address sum
// - size field 00 byte, 01 word, 10 long
// - memory select: data regs or predecrement address regs
// - count source: immediate count or count register
// - shift direction 0 right, 1 left
// - type 00 asl, 01 lsl, 10 rox, 11 rot
// - memory shift: line 1110, bits7-6 both set
// - memory table second word fields decoded
// - register pair endpoints from both words
// - four table variants, byte word long
// - memory table or two-register table accepted
// - offset index[15:8], fraction index[7:0], interpolate
// - up to 257 entries, 256 levels
// - index low sixteen bits unsigned, upper ignored
// - rounded variants round to nearest even
`ifndef OP_DECODE_DEFS_VH
`define OP_DECODE_DEFS_VH

`define LINE_SWAP      4'hc
`define LINE_SUM       4'hd
`define LINE_SHIFT     4'he
`define LINE_TABLE     4'hf
`define SWAP_PATTERN   5'h11
`define TABLE_HI_REG   7'h40
`define TABLE_HI_MEM   10'h3e0
`define TABLE_W1_MEM   2'h1
`define TABLE_W1_REG   2'h0
`define SIZE_BYTE      2'h0
`define SIZE_WORD      2'h1
`define SIZE_LONG      2'h2
`define SIZE_BAD       2'h3
`define OPM_ADDR_WORD  3'h3
`define OPM_ADDR_LONG  3'h7
`define SHT_ARITH      2'h0
`define SHT_LOGIC      2'h1
`define SHT_ROTX       2'h2
`define SHT_ROT        2'h3
`define FRAC_BITS      8
`define MEM_SHIFT_CNT  6'h01
`define MAX_SHIFT      6'h3f
`define TOP_BYTE       5'h07
`define TOP_WORD       5'h0f
`define TOP_LONG       5'h1f
`define HALF_LSB       8'h80

// operation class codes
`define OP_NONE        4'h0
`define OP_SWAP        4'h1
`define OP_SUM_TO_REG  4'h2
`define OP_SUM_TO_EA   4'h3
`define OP_ADDR_SUM    4'h4
`define OP_EXT_SUM     4'h5
`define OP_SHIFT_REG   4'h6
`define OP_SHIFT_MEM   4'h7
`define OP_TABLE_MEM   4'h8
`define OP_TABLE_REG   4'h9

`endif

// ===== table_interp.v
// table interpolation arithmetic: endpoints and fraction to result
`timescale 1ns/10ps
`default_nettype none
`include "op_decode_defs.vh"

module table_interp
(
   input  wire        [31:0] entry_lo,      // entry n, sign or zero extended
   input  wire        [31:0] entry_hi,      // entry n+1
   input  wire        [7:0]  fraction,      // interpolation fraction
   input  wire               is_unsigned,   // 1 unsigned variant
   input  wire               is_raw,        // 1 unrounded variant
   output wire        [39:0] result         // raw: 32.8, rounded: low 32 used
);

   wire signed [33:0] diff;
   wire signed [43:0] prod;
   wire signed [43:0] full;
   wire        [31:0] ip;
   wire        [7:0]  fp;
   wire               up;

   // extend endpoints two bits per variant type
   assign diff = {{2{is_unsigned ? 1'b0 : entry_hi[31]}}, entry_hi}
               - {{2{is_unsigned ? 1'b0 : entry_lo[31]}}, entry_lo};
   assign prod = diff * $signed({1'b0, fraction});
   assign full = {{4{is_unsigned ? 1'b0 : entry_lo[31]}}, entry_lo, 8'h00} + prod;
   assign ip   = full[39:8];
   assign fp   = full[7:0];
   assign up   = (fp > `HALF_LSB) || ((fp == `HALF_LSB) && ip[0]);
   assign result = is_raw ? full[39:0] : {8'h00, ip + {31'h0, up}};

endmodule
`default_nettype wire

// ===== table_source.sv
// datapath stand-in: linear table entries at the index offset
`timescale 1ns/10ps
`default_nettype none
module table_source
(
   input  wire logic [31:0] index_operand_reg, // index, low half used
   input  wire logic [31:0] base,              // entry zero value
   input  wire logic [31:0] step,              // entry spacing
   output logic      [31:0] entry_n,           // entry at offset
   output logic      [31:0] entry_n1           // next entry
);
   // entries fetched by offset
   assign entry_n  = base + step * {24'h0, index_operand_reg[15:8]};
   assign entry_n1 = entry_n + step;
endmodule
`default_nettype wire
